// >>> rtl/scm_pkg.sv
// package: constants, types and state codes for the shutdown condition monitor
package scm_pkg;

    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned LB_WAIT_MS      = 8000;
    localparam int unsigned OVERTMP_WAIT_MS = 1000;
    localparam int unsigned OVERTMP_DEB_MS  = 62;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    // longest waits round down, least debounce time rounds up (strictly more than 62 ms)
    localparam longint unsigned LB_WAIT_CYC      = 64'(LB_WAIT_MS) * CYC_PER_MS;
    localparam longint unsigned OVERTMP_WAIT_CYC = 64'(OVERTMP_WAIT_MS) * CYC_PER_MS;
    localparam longint unsigned OVERTMP_DEB_CYC  = 64'(OVERTMP_DEB_MS) * CYC_PER_MS + 1;

    // debounce choices for the battery monitor, in ms
    localparam int unsigned LB_DEB0_MS = 0;
    localparam int unsigned LB_DEB1_MS = 1;
    localparam int unsigned LB_DEB2_MS = 10;
    localparam int unsigned LB_DEB3_MS = 50;

    localparam int CNT_W = 32;
    localparam int FLAG_W = 8;
    localparam int LB_BIT      = 0;
    localparam int OVERTMP_BIT = 1;
    localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;
    localparam logic [FLAG_W-1:0] MASK_RST = 8'hFF;

    typedef enum logic [1:0] {
        SCM_NOPOWER = 2'b00,
        SCM_SAVE    = 2'b01,
        SCM_STANDBY = 2'b10,
        SCM_ACTIVE  = 2'b11
    } scm_pstate_t;

    typedef struct packed {
        logic       below_low;   // comparator: vbat below threshold
        logic       above_hyst;  // comparator: vbat above threshold plus hysteresis
        logic       tmp_hot;     // comparator: temperature past trip point
        logic       tmp_cool;    // comparator: temperature below trip minus hysteresis
    } scm_cmp_t;

    typedef struct packed {
        logic              rd;     // one-cycle read-and-clear strobe
        logic [FLAG_W-1:0] mask;   // 1 = masked
    } scm_host_t;

endpackage

// >>> rtl/scm_timer.sv
// module: generic run/expire counter used for debounce and forced-standby waits
`timescale 1ns/1ps
module scm_timer (
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic             i_run,
    input  wire logic [scm_pkg::CNT_W-1:0] i_limit,
    output logic                  o_done
);
    import scm_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } scm_tmr_t;

    scm_tmr_t st_r;
    scm_tmr_t st_nxt;

    // done stays high while run holds; dropping run cancels the count
    always_comb begin
        st_nxt = st_r;
        if (!i_run) begin
            st_nxt.cnt  = '0;
            st_nxt.done = 1'b0;
        end else if (!st_r.done) begin
            if (st_r.cnt + 1'b1 >= i_limit) begin
                st_nxt.done = 1'b1;
            end
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_done = st_r.done;

endmodule

// >>> rtl/scm_monitor.sv
// module: low-battery and over-temperature supervision with forced standby
`timescale 1ns/1ps
module scm_monitor (
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset,
    input  wire scm_pkg::scm_pstate_t        i_pstate,
    input  wire scm_pkg::scm_cmp_t           i_cmp,
    input  wire logic [1:0]                  i_lb_deb_sel,
    input  wire scm_pkg::scm_host_t          i_host,
    output logic [scm_pkg::FLAG_W-1:0]       o_flags,
    output logic                             o_irq_n,
    output logic                             o_force_standby,
    output logic                             o_tsens_en
);
    import scm_pkg::*;

    // ****************************************
    // synchronisers for comparator outputs
    // ****************************************
    scm_cmp_t cmp_m_r;
    scm_cmp_t cmp_s_r;

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cmp_m_r <= '0;
            cmp_s_r <= '0;
        end else begin
            cmp_m_r <= i_cmp;
            cmp_s_r <= cmp_m_r;
        end
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        scm_pstate_t       prev;
        logic              lb_armed;   // rearmed after rising past hysteresis
        logic              tmp_hot;    // hysteresis-latched hot level
        logic              tmp_fired;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] held;       // events caught during a read
        logic              lb_wait;
        logic              tmp_wait;
        logic              force_sb;
        logic              irq_n;
        logic              tsens_en;
    } scm_state_t;

    scm_state_t st_r;
    scm_state_t st_nxt;

    logic              active;
    logic              leave_active;
    logic              lb_deb_done;
    logic              tmp_deb_done;
    logic              lb_to_done;
    logic              tmp_to_done;
    logic [CNT_W-1:0]  lb_deb_lim;
    logic [FLAG_W-1:0] ev;

    assign active       = (i_pstate == SCM_ACTIVE);
    assign leave_active = (st_r.prev == SCM_ACTIVE) && (i_pstate == SCM_STANDBY);

    // debounce length select; zero setting still costs one cycle
    always_comb begin
        unique case (i_lb_deb_sel)
            2'b00: lb_deb_lim = CNT_W'(LB_DEB0_MS * CYC_PER_MS + 1);
            2'b01: lb_deb_lim = CNT_W'(LB_DEB1_MS * CYC_PER_MS);
            2'b10: lb_deb_lim = CNT_W'(LB_DEB2_MS * CYC_PER_MS);
            2'b11: lb_deb_lim = CNT_W'(LB_DEB3_MS * CYC_PER_MS);
        endcase
    end

    // ****************************************
    // timers
    // ****************************************
    // battery debounce ignores power state entirely
    scm_timer u_lb_deb (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_run   (cmp_s_r.below_low & st_r.lb_armed),
        .i_limit (lb_deb_lim),
        .o_done  (lb_deb_done)
    );

    // temperature debounce runs only in active (from i_pstate), while hot is latched and not yet fired
    scm_timer u_tmp_deb (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_run   (active & st_r.tmp_hot & ~st_r.tmp_fired),
        .i_limit (CNT_W'(OVERTMP_DEB_CYC)),
        .o_done  (tmp_deb_done)
    );

    // waits run only while active, so leaving active cancels them
    scm_timer u_lb_to (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_run   (st_r.lb_wait & active),
        .i_limit (CNT_W'(LB_WAIT_CYC)),
        .o_done  (lb_to_done)
    );

    scm_timer u_tmp_to (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_run   (st_r.tmp_wait & active),
        .i_limit (CNT_W'(OVERTMP_WAIT_CYC)),
        .o_done  (tmp_to_done)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = i_pstate;
        ev          = '0;

        // fixed trip point from the comparator, hysteresis by latch
        if (!active) begin
            st_nxt.tmp_hot   = 1'b0;
            st_nxt.tmp_fired = 1'b0;
        end else if (cmp_s_r.tmp_hot) begin
            st_nxt.tmp_hot = 1'b1;
        end else if (cmp_s_r.tmp_cool) begin
            st_nxt.tmp_hot   = 1'b0;
            st_nxt.tmp_fired = 1'b0;
        end

        if (tmp_deb_done && !st_r.tmp_fired) begin
            ev[OVERTMP_BIT]  = 1'b1;
            st_nxt.tmp_fired = 1'b1;
        end

        if (lb_deb_done && st_r.lb_armed) begin
            ev[LB_BIT]      = 1'b1;
            st_nxt.lb_armed = 1'b0;
        end else if (cmp_s_r.above_hyst) begin
            st_nxt.lb_armed = 1'b1;
        end

        // timers start on event only when the host has something to act on
        if (ev[LB_BIT] && active) begin
            st_nxt.lb_wait = 1'b1;
        end
        if (ev[OVERTMP_BIT]) begin
            st_nxt.tmp_wait = 1'b1;
        end
        if (!active) begin
            st_nxt.lb_wait  = 1'b0;
            st_nxt.tmp_wait = 1'b0;
        end

        // read-and-clear: flags go out, arrivals wait in held
        if (i_host.rd) begin
            st_nxt.flags = '0;
            st_nxt.held  = st_r.held | ev;
        end else begin
            st_nxt.flags = st_r.flags | st_r.held | ev;
            st_nxt.held  = '0;
        end

        // a set in the same cycle as the transition still wins; under a read it waits in held
        if (leave_active) begin
            st_nxt.flags[LB_BIT]      = ev[LB_BIT] & ~i_host.rd;
            st_nxt.flags[OVERTMP_BIT] = ev[OVERTMP_BIT] & ~i_host.rd;
            st_nxt.held[LB_BIT]       = ev[LB_BIT] & i_host.rd;
            st_nxt.held[OVERTMP_BIT]  = ev[OVERTMP_BIT] & i_host.rd;
        end

        st_nxt.force_sb = active & (lb_to_done | tmp_to_done);
        st_nxt.irq_n    = ~(active & |(st_nxt.flags & ~i_host.mask));
        st_nxt.tsens_en = active;
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            st_r          <= '0;
            st_r.lb_armed <= 1'b1;
            st_r.flags    <= FLAG_RST;
            st_r.irq_n    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_flags         = st_r.flags;
    assign o_irq_n         = st_r.irq_n;
    assign o_force_standby = st_r.force_sb;
    assign o_tsens_en      = st_r.tsens_en;

    // ****************************************
    // checks
    // ****************************************
    a_irq_masked_off: assert property (@(posedge i_mclk) disable iff (i_reset)
        !active |=> o_irq_n)
        else $error("irq asserted outside active");

    a_tsens_only_active: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(o_tsens_en) |-> $past(active))
        else $error("sensor enabled outside active");

    a_flags_cleared_sb: assert property (@(posedge i_mclk) disable iff (i_reset)
        leave_active && ev == '0 |=> !o_flags[LB_BIT] && !o_flags[OVERTMP_BIT])
        else $error("flags not cleared on standby entry");

    a_read_clears: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_host.rd |=> o_flags == '0)
        else $error("read did not clear flags");

    a_read_keeps_event: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_host.rd && ev[LB_BIT] && !leave_active ##1 !i_host.rd && !leave_active
        |=> o_flags[LB_BIT])
        else $error("event during read lost");

    a_force_needs_wait: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_force_standby |-> $past(st_r.lb_wait || st_r.tmp_wait, 2))
        else $error("forced standby without pending event");

    a_force_only_active: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_force_standby |-> $past(active))
        else $error("forced standby outside active");

    a_lb_rearm_needed: assert property (@(posedge i_mclk) disable iff (i_reset)
        ev[LB_BIT] |=> !st_r.lb_armed)
        else $error("battery monitor not disarmed after event");

    a_tmp_event_hot: assert property (@(posedge i_mclk) disable iff (i_reset)
        ev[OVERTMP_BIT] |-> $past(st_r.tmp_hot, 8) && $past(active, 8))
        else $error("over-temperature event without sustained hot level");

endmodule

// >>> testbench/scm_host_model.sv
// file: host controller model driving power state, interrupt mask and read strobe
`timescale 1ns/1ps
module scm_host_model
(
    input  wire logic                   i_mclk,
    input  wire logic                   i_irq_n,
    input  wire logic [scm_pkg::FLAG_W-1:0] i_flags,
    input  wire logic                   i_auto,
    output scm_pkg::scm_pstate_t        o_pstate,
    output scm_pkg::scm_host_t          o_host
);
    import scm_pkg::*;
    logic [FLAG_W-1:0] last_rd;

    initial begin
        o_pstate = SCM_STANDBY;
        o_host   = '{rd: 1'b0, mask: 8'hFF};
        last_rd  = 8'h00;
    end

    task automatic set_state(input scm_pstate_t s);
        @(negedge i_mclk);
        o_pstate = s;
    endtask

    task automatic set_mask(input logic [FLAG_W-1:0] m);
        @(negedge i_mclk);
        o_host.mask = m;
    endtask

    // strobe held one cycle; data taken at the very edge that samples it
    task automatic read_flags();
        @(negedge i_mclk);
        o_host.rd = 1'b1;
        @(posedge i_mclk);
        last_rd = i_flags;
        @(negedge i_mclk);
        o_host.rd = 1'b0;
    endtask

    // a serviced shut-down event is answered by a standby request
    always @(negedge i_mclk) begin
        if (i_auto && i_irq_n === 1'b0 && o_pstate == SCM_ACTIVE) begin
            read_flags();
            set_state(SCM_STANDBY);
        end
    end
endmodule

// >>> testbench/tb_top.sv
// file: self-checking testbench for the shutdown condition monitor
`timescale 1ns/1ps
module tb_top;
    import scm_pkg::*;
    logic              mclk = 1'b0;
    logic              reset = 1'b1;
    scm_pstate_t       pstate;
    scm_cmp_t          cmp = '0;
    logic [1:0]        deb_sel = 2'h0;
    scm_host_t         host;
    logic [FLAG_W-1:0] flags;
    logic              irq_n;
    logic              force_sb;
    logic              tsens_en;
    logic              auto = 1'b0;
    int                err_total = 0;
    int                checks_done = 0;

    always #10 mclk = ~mclk;

    scm_monitor scm_monitor_i (.i_mclk(mclk), .i_reset(reset), .i_pstate(pstate), .i_cmp(cmp),
        .i_lb_deb_sel(deb_sel), .i_host(host), .o_flags(flags), .o_irq_n(irq_n),
        .o_force_standby(force_sb), .o_tsens_en(tsens_en));
    scm_host_model scm_host_model_i (.i_mclk(mclk), .i_irq_n(irq_n), .i_flags(flags),
        .i_auto(auto), .o_pstate(pstate), .o_host(host));

    // ****************
    // helpers
    // ****************
    task automatic check(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wait_flag(input int b, input int lim, output logic got);
        got = 1'b0;
        for (int k = 0; k < lim && !got; k++) begin
            @(negedge mclk);
            got = (flags[b] === 1'b1);
        end
    endtask

    task automatic conclude();
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        check(flags === FLAG_RST && irq_n === 1'b1 && force_sb === 1'b0, "reset outputs");
        scm_host_model_i.set_state(SCM_ACTIVE);
        cyc(2);
        check(tsens_en === 1'b1, "sensor off in active");
        scm_host_model_i.set_state(SCM_STANDBY);
        cyc(2);
        check(tsens_en === 1'b0, "sensor on in standby");
        scm_host_model_i.set_state(SCM_SAVE);
        cyc(2);
        check(tsens_en === 1'b0 && irq_n === 1'b1, "sensor on in save");
        scm_host_model_i.set_state(SCM_ACTIVE);
        cyc(2);
    endtask

    task automatic t_low_battery_event();
        logic got;
        scm_host_model_i.set_mask(8'hFE);
        cmp.below_low = 1'b1;
        wait_flag(LB_BIT, 10, got);
        check(got, "low battery flag missing");
        cyc(2);
        check(irq_n === 1'b0 && flags[OVERTMP_BIT] === 1'b0, "irq not asserted");
        scm_host_model_i.set_mask(8'hFF);
        cyc(2);
        check(irq_n === 1'b1 && flags[LB_BIT] === 1'b1, "masked event drives irq");
        scm_host_model_i.read_flags();
        cyc(1);
        check(scm_host_model_i.last_rd[LB_BIT] === 1'b1 && flags === 8'h00, "read and clear");
        cyc(20);
        check(flags[LB_BIT] === 1'b0, "event repeated without recovery");
        cmp.below_low = 1'b0;
        cmp.above_hyst = 1'b1;
        cyc(5);
        scm_host_model_i.set_state(SCM_STANDBY);
        cmp.above_hyst = 1'b0;
        cmp.below_low = 1'b1;
        wait_flag(LB_BIT, 10, got);
        check(got, "monitor idle outside active");
        check(irq_n === 1'b1, "irq outside active");
        scm_host_model_i.set_mask(8'hFE);
        scm_host_model_i.set_state(SCM_ACTIVE);
        cyc(3);
        check(irq_n === 1'b0, "pending event not signalled");
        scm_host_model_i.set_state(SCM_STANDBY);
        cyc(2);
        check(flags[LB_BIT] === 1'b0 && irq_n === 1'b1, "flag kept over standby entry");
    endtask

    // read strobe placed on the event edge (sync 2 + limit 1 + 1); event must survive it
    task automatic t_rd_race();
        cmp.below_low = 1'b0;
        cmp.above_hyst = 1'b1;
        cyc(5);
        cmp.above_hyst = 1'b0;
        cmp.below_low = 1'b1;
        cyc(2);
        scm_host_model_i.read_flags();
        cyc(2);
        check(flags[LB_BIT] === 1'b1, "event lost during read");
        scm_host_model_i.read_flags();
        cyc(1);
    endtask

    // longer filter setting; runs in standby, so it also shows the monitor awake there
    task automatic t_deb();
        logic got;
        cmp.below_low = 1'b0;
        cmp.above_hyst = 1'b1;
        deb_sel = 2'h1;
        cyc(5);
        cmp.above_hyst = 1'b0;
        cmp.below_low = 1'b1;
        wait_flag(LB_BIT, CYC_PER_MS - 10, got);
        check(got === 1'b0, "debounce too short");
        wait_flag(LB_BIT, 30, got);
        check(got, "debounce too long");
        scm_host_model_i.read_flags();
        cyc(1);
    endtask

    // full 62 ms debounce is out of run budget; only the early side is shown
    task automatic t_temp();
        scm_host_model_i.set_state(SCM_ACTIVE);
        cmp.tmp_hot = 1'b1;
        cyc(5000);
        check(flags[OVERTMP_BIT] === 1'b0 && force_sb === 1'b0, "early over-temperature event");
        scm_host_model_i.set_state(SCM_STANDBY);
        cyc(2);
        check(tsens_en === 1'b0 && flags[OVERTMP_BIT] === 1'b0, "sensor alive outside active");
        cmp.tmp_hot = 1'b0;
        cmp.tmp_cool = 1'b1;
    endtask

    task automatic t_auto();
        cmp.below_low = 1'b0;
        cmp.above_hyst = 1'b1;
        deb_sel = 2'h0;
        scm_host_model_i.set_state(SCM_ACTIVE);
        cyc(3);
        auto = 1'b1;
        cmp.above_hyst = 1'b0;
        cmp.below_low = 1'b1;
        for (int k = 0; k < 20 && pstate !== SCM_STANDBY; k++) begin
            cyc(1);
        end
        cyc(2);
        check(pstate === SCM_STANDBY && flags === 8'h00 && irq_n === 1'b1, "serviced event left open");
        auto = 1'b0;
    endtask

    initial begin
        repeat (6) @(negedge mclk);
        reset = 1'b0;
        cyc(1);
        t_reset();
        t_low_battery_event();
        t_rd_race();
        t_deb();
        t_temp();
        t_auto();
        conclude();
    end

    // whole run is near 55k cycles; 80k cycles means a hang
    initial begin
        #1_600_000;
        err_total++;
        conclude();
    end
endmodule
